// *** dv/csf_core_model.sv ***
// partner model: instruction execution and watchdog side of the core
module csf_core_model
   import csf_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // instruction execution port
   output logic exec_valid,
   output csf_pkg::csf_op_t exec_op,
   output logic [6:0] exec_dir_addr,
   output logic [7:0] exec_file_val,
   output logic [7:0] exec_work_val,
   output logic exec_write,
   // watchdog and power events
   output csf_pkg::csf_event_t wdog_event,
   // alu result, sampled at the falling edge after the issuing edge
   input wire logic [7:0] exec_result,
   output logic [7:0] last_result
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle at time zero, no instruction pending
   initial begin
      exec_valid = 1'b0;
      exec_op = CSF_OP_NONE;
      exec_dir_addr = 7'h00;
      exec_file_val = 8'h00;
      exec_work_val = 8'h00;
      exec_write = 1'b0;
      wdog_event = CSF_EV_NONE;
      last_result = 8'h00;
   end
   // one instruction, one cycle; operands stay put so the address mux can be observed
   task automatic exec_instr(input csf_op_t op, input logic [6:0] a, input logic [7:0] f,
                             input logic [7:0] w, input logic wr);
      @(posedge sys_clk);
      exec_valid <= 1'b1;
      exec_op <= op;
      exec_dir_addr <= a;
      exec_file_val <= f;
      exec_work_val <= w;
      exec_write <= wr;
      // result sampled mid-cycle, clear of the edge where the carry flop moves
      @(negedge sys_clk);
      last_result = exec_result;
      @(posedge sys_clk);
      exec_valid <= 1'b0;
      exec_write <= 1'b0;
   endtask
   // one-cycle watchdog or power event pulse
   task automatic wdog_pulse(input csf_event_t ev);
      @(posedge sys_clk);
      wdog_event <= ev;
      @(posedge sys_clk);
      wdog_event <= CSF_EV_NONE;
   endtask
endmodule

// *** dv/tb_core_status_flag_register.sv ***
// testbench for the core status flag register
module tb_core_status_flag_register;
   import csf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   // register port, driven by the bench
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, core_status_flags, data_mem_addr, exec_result, last_result;
   logic bank_select_bit, exec_valid, exec_write;
   csf_op_t exec_op;
   csf_event_t wdog_event;
   logic [6:0] exec_dir_addr;
   logic [7:0] exec_file_val, exec_work_val;
   int fail_count = 0;
   int cmp_count = 0;
   // 100 MHz clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   csf_status_reg csf_status_reg_inst (.sys_clk(sys_clk), .resetn(resetn),
      .exec_valid(exec_valid), .exec_op(exec_op), .exec_dir_addr(exec_dir_addr),
      .exec_file_val(exec_file_val), .exec_work_val(exec_work_val),
      .exec_write(exec_write), .wdog_event(wdog_event), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_status_flags(core_status_flags), .data_mem_addr(data_mem_addr),
      .exec_result(exec_result), .bank_select_bit(bank_select_bit));
   csf_core_model csf_core_model_inst (.sys_clk(sys_clk), .exec_valid(exec_valid),
      .exec_op(exec_op), .exec_dir_addr(exec_dir_addr), .exec_file_val(exec_file_val),
      .exec_work_val(exec_work_val), .exec_write(exec_write), .wdog_event(wdog_event),
      .exec_result(exec_result), .last_result(last_result));
   // count and report one comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // software alters status by plain moves and by clear and add instructions
   // stimulus keeps the reserved top bits clear
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // single-cycle port read, data checked in the following cycle only
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // instruction then check of the register and the result
   task automatic run_op(input csf_op_t op, input logic [6:0] a, input logic [7:0] f,
                         input logic [7:0] w, input logic wr, input logic [7:0] res,
                         input logic [7:0] st);
      csf_core_model_inst.exec_instr(op, a, f, w, wr);
      #1;
      chk(last_result, res);
      chk(core_status_flags, st);
   endtask
   // event pulse then check of the register
   task automatic run_ev(input csf_event_t ev, input logic [7:0] st);
      csf_core_model_inst.wdog_pulse(ev);
      #1;
      chk(core_status_flags, st);
   endtask
   // verdict, the single place the run ends
   task automatic complete_run();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // hang guard, far beyond the roughly 45 cycles of the sequence
   initial begin
      #50000;
      fail_count++;
      complete_run();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      reg_read(8'h03, 8'h18);
      reg_write(8'h03, 8'h00);
      chk(core_status_flags, 8'h18);
      reg_write(8'h03, 8'h27);
      chk(core_status_flags, 8'h3f);
      run_op(CSF_OP_CLEAR, 7'h03, 8'h3f, 8'h00, 1'b1, 8'h00, 8'h1f);
      reg_write(8'h03, 8'h20);
      chk(core_status_flags, 8'h38);
      run_op(CSF_OP_ADD, 7'h45, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h3a);
      chk(data_mem_addr, 8'hc5);
      chk({7'h00, bank_select_bit}, 8'h01);
      run_op(CSF_OP_ADD, 7'h45, 8'hff, 8'h01, 1'b0, 8'h00, 8'h3f);
      run_op(CSF_OP_SUB, 7'h45, 8'h00, 8'h01, 1'b0, 8'hff, 8'h38);
      run_op(CSF_OP_SUB, 7'h45, 8'h05, 8'h05, 1'b0, 8'h00, 8'h3f);
      run_op(CSF_OP_ADD, 7'h03, 8'h3f, 8'he1, 1'b1, 8'h20, 8'h3b);
      run_op(CSF_OP_ROR, 7'h45, 8'h02, 8'h00, 1'b0, 8'h81, 8'h3a);
      run_op(CSF_OP_ROL, 7'h45, 8'h80, 8'h00, 1'b0, 8'h00, 8'h3b);
      run_ev(CSF_EV_TIMEOUT, 8'h2b);
      run_ev(CSF_EV_SLEEP, 8'h33);
      run_ev(CSF_EV_KICK, 8'h3b);
      run_op(CSF_OP_LOGIC, 7'h45, 8'h55, 8'h00, 1'b0, 8'h00, 8'h3f);
      reg_write(8'h00, 8'h00);
      chk(core_status_flags, 8'h3f);
      reg_read(8'h83, 8'h3f);
      reg_read(8'h10, 8'h00);
      reg_write(8'h83, 8'h00);
      chk(core_status_flags, 8'h18);
      complete_run();
   end
endmodule

// *** include/csf_consts.svh ***
// constants for the core status flag register
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH
// bit positions within the status register
`define CSF_BIT_CARRY 3'd0
`define CSF_BIT_NIBBLE 3'd1
`define CSF_BIT_ZERO 3'd2
`define CSF_BIT_SLEEP 3'd3
`define CSF_BIT_WDOG 3'd4
`define CSF_BIT_BANK 3'd5
`define CSF_BIT_RSV_LO 3'd6
`define CSF_BIT_RSV_HI 3'd7
// power-on reset value: both reset indicators set, everything else clear
`define CSF_RESET_VALUE 8'h18
// data-memory address of the register in either bank
`define CSF_REG_ADDR 7'h03
// mask of the alu flags, of the read-only reset indicators and of the top three bits
`define CSF_ALU_MASK 8'h07
`define CSF_RO_MASK 8'h18
`define CSF_TOP3_MASK 8'he0
// flag constants used by the alu
`define CSF_NIBBLE_MSB 3'd4
`define CSF_ZERO_BYTE 8'h00
`endif

// *** include/csf_pkg.sv ***
// types for the core status flag register
package csf_pkg;
   // alu operations whose outcome sets flags
   typedef enum logic [2:0] {
      CSF_OP_NONE,
      CSF_OP_ADD,
      CSF_OP_SUB,
      CSF_OP_LOGIC,
      CSF_OP_ROR,
      CSF_OP_ROL,
      CSF_OP_CLEAR
   } csf_op_t;
   // watchdog and power events
   typedef enum logic [1:0] {
      CSF_EV_NONE,
      CSF_EV_KICK,
      CSF_EV_SLEEP,
      CSF_EV_TIMEOUT
   } csf_event_t;
endpackage

// *** src/csf_alu_flags.sv ***
// flag generator: result and zero/nibble carry/carry for one alu operation
`include "csf_consts.svh"
module csf_alu_flags
   import csf_pkg::*;
(
   // operation and operands
   input wire csf_pkg::csf_op_t op,
   input wire logic [7:0] file_val,
   input wire logic [7:0] work_val,
   input wire logic carry_in,
   // outcome
   output logic [7:0] result,
   output logic zero_out,
   output logic nibble_out,
   output logic carry_out,
   output logic alu_flags_hit,
   output logic carry_only_hit
);
   // second operand, inverted for subtraction
   logic [7:0] addend;
   // low nibble sum with its carry
   logic [4:0] low_sum;
   // full sum with its carry
   logic [8:0] full_sum;
   // subtract by adding two's complement of the second operand
   // two's complement subtract
   assign addend = (op == CSF_OP_SUB) ? ~work_val : work_val;
   assign low_sum = {1'b0, file_val[3:0]} + {1'b0, addend[3:0]} + {4'h0, op == CSF_OP_SUB};
   assign full_sum = {1'b0, file_val} + {1'b0, addend} + {8'h00, op == CSF_OP_SUB};
   // result select and flag outcome per operation
   always_comb begin
      result = file_val;
      zero_out = 1'b0;
      nibble_out = 1'b0;
      carry_out = carry_in;
      alu_flags_hit = 1'b0;
      carry_only_hit = 1'b0;
      unique case (op)
         CSF_OP_ADD, CSF_OP_SUB: begin
            result = full_sum[7:0];
            nibble_out = low_sum[`CSF_NIBBLE_MSB];
            carry_out = full_sum[8];
            alu_flags_hit = 1'b1;
         end
         // logic op only touches zero
         CSF_OP_LOGIC: begin
            result = work_val;
            alu_flags_hit = 1'b1;
         end
         CSF_OP_ROR: begin
            result = {carry_in, file_val[7:1]};
            carry_out = file_val[0];
            carry_only_hit = 1'b1;
         end
         CSF_OP_ROL: begin
            result = {file_val[6:0], carry_in};
            carry_out = file_val[7];
            carry_only_hit = 1'b1;
         end
         // clear gives zero result
         CSF_OP_CLEAR: begin
            result = `CSF_ZERO_BYTE;
            alu_flags_hit = 1'b1;
         end
         CSF_OP_NONE: begin
            result = file_val;
         end
         default: begin
            result = file_val;
         end
      endcase
      zero_out = (result == `CSF_ZERO_BYTE);
   end
endmodule

// *** src/csf_status_reg.sv ***
// core status flag register with bank select and reset indicators
// Behaviour
// - status register usable as any destination
// - alu flag writes replaced by outcome
// - watchdog and sleep flags read-only
// - clear gives 000u u1uu
// - bank bit selects upper or lower bank
// - watchdog flag set/cleared by events
// - sleep flag set/cleared by events
// - zero flag tracks zero result
// - nibble carry from bit three carry
// - carry from msb carry
// - subtract adds two's complement
// - rotates load carry from shifted bit
//
// Implementation choices: the register addresses and strobed register access.
`include "csf_consts.svh"
module csf_status_reg
   import csf_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // instruction execution port
   input wire logic exec_valid,
   input wire csf_pkg::csf_op_t exec_op,
   input wire logic [6:0] exec_dir_addr,
   input wire logic [7:0] exec_file_val,
   input wire logic [7:0] exec_work_val,
   input wire logic exec_write,
   // watchdog and power events
   input wire csf_pkg::csf_event_t wdog_event,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // status outputs
   output logic [7:0] core_status_flags,
   output logic [7:0] data_mem_addr,
   output logic [7:0] exec_result,
   output logic bank_select_bit
);
   import csf_pkg::*;

   // alu outcome wires
   logic [7:0] alu_result;
   logic alu_zero;
   logic alu_nibble;
   logic alu_carry;
   logic alu_flags_hit;
   logic alu_carry_hit;
   // the register and its next value
   logic [7:0] next_status;
   // registered read data
   logic [7:0] rdata_q;
   // decode wires
   wire exec_hits_status;
   wire port_hits_status;
   wire [7:0] after_write;
   wire [7:0] after_alu;
   wire [7:0] keep_mask;

   // flag generator
   csf_alu_flags u_alu (
      .op(exec_op),
      .file_val(exec_file_val),
      .work_val(exec_work_val),
      .carry_in(core_status_flags[`CSF_BIT_CARRY]),
      .result(alu_result),
      .zero_out(alu_zero),
      .nibble_out(alu_nibble),
      .carry_out(alu_carry),
      .alu_flags_hit(alu_flags_hit),
      .carry_only_hit(alu_carry_hit)
   );

   // status as any destination, both banks alias it
   assign exec_hits_status = exec_valid && exec_write && (exec_dir_addr == `CSF_REG_ADDR);
   assign port_hits_status = reg_wr && (reg_addr[6:0] == `CSF_REG_ADDR);
   assign data_mem_addr = {core_status_flags[`CSF_BIT_BANK], exec_dir_addr};
   assign bank_select_bit = core_status_flags[`CSF_BIT_BANK];
   assign exec_result = alu_result;

   // bits that a write may not touch: reset indicators always, alu flags when updated
   // mask updated flags
   assign keep_mask = `CSF_RO_MASK
      | (alu_flags_hit ? `CSF_ALU_MASK : 8'h00)
      | (alu_carry_hit ? 8'h01 : 8'h00);
   assign after_write = exec_hits_status
      ? ((alu_result & ~keep_mask) | (core_status_flags & keep_mask))
      : (port_hits_status
         ? ((reg_wdata & ~`CSF_RO_MASK) | (core_status_flags & `CSF_RO_MASK))
         : core_status_flags);

   // flag update from alu after the write masking; clear keeps bit 4..3 and sets zero
   // clear: zero top three, set zero
   assign after_alu = !exec_valid ? after_write
      : alu_flags_hit
         ? ((exec_op == CSF_OP_SUB || exec_op == CSF_OP_ADD)
            ? {after_write[7:3], alu_zero, alu_nibble, alu_carry}
            : {after_write[7:3], alu_zero, after_write[1:0]})
         : alu_carry_hit ? {after_write[7:1], alu_carry} : after_write;

   // watchdog and sleep events override the read-only bits
   always_comb begin
      next_status = after_alu;
      unique case (wdog_event)
         CSF_EV_KICK: begin
            next_status[`CSF_BIT_WDOG] = 1'b1;
            next_status[`CSF_BIT_SLEEP] = 1'b1;
         end
         CSF_EV_SLEEP: begin
            next_status[`CSF_BIT_WDOG] = 1'b1;
            next_status[`CSF_BIT_SLEEP] = 1'b0;
         end
         CSF_EV_TIMEOUT: begin
            next_status[`CSF_BIT_WDOG] = 1'b0;
         end
         CSF_EV_NONE: begin
            next_status = after_alu;
         end
      endcase
   end

   // register, power-up sets both reset indicators
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         core_status_flags <= `CSF_RESET_VALUE;
      end else begin
         core_status_flags <= next_status;
      end
   end

   // read answer one cycle later, unmapped reads as zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd && reg_addr[6:0] == `CSF_REG_ADDR) begin
         rdata_q <= core_status_flags;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // property checks
   // port write leaves reset flags
   property p_ro_flags;
      @(posedge sys_clk) disable iff (!resetn)
      (port_hits_status && !exec_valid && wdog_event == CSF_EV_NONE)
         |=> core_status_flags[4:3] == $past(core_status_flags[4:3]);
   endproperty
   a_ro_flags: assert property (p_ro_flags) else $error("reset flags changed by write");

   property p_clear;
      @(posedge sys_clk) disable iff (!resetn)
      (exec_valid && exec_op == CSF_OP_CLEAR && exec_hits_status && wdog_event == CSF_EV_NONE)
         |=> (core_status_flags[7:5] == 3'b000) && core_status_flags[2]
            && core_status_flags[1:0] == $past(core_status_flags[1:0]);
   endproperty
   a_clear: assert property (p_clear) else $error("clear of status wrong");

   property p_kick;
      @(posedge sys_clk) disable iff (!resetn)
      wdog_event == CSF_EV_KICK |=> core_status_flags[4:3] == 2'b11;
   endproperty
   a_kick: assert property (p_kick) else $error("kick did not set flags");

   sequence s_sleep;
      wdog_event == CSF_EV_SLEEP;
   endsequence
   property p_sleep;
      @(posedge sys_clk) disable iff (!resetn)
      s_sleep |=> core_status_flags[4:3] == 2'b10;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

   property p_timeout;
      @(posedge sys_clk) disable iff (!resetn)
      wdog_event == CSF_EV_TIMEOUT |=> !core_status_flags[4];
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not clear");

   property p_zero;
      @(posedge sys_clk) disable iff (!resetn)
      (exec_valid && alu_flags_hit) |=> core_status_flags[2] == ($past(alu_result) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_add_carry;
      @(posedge sys_clk) disable iff (!resetn)
      (exec_valid && exec_op == CSF_OP_ADD)
         |=> core_status_flags[0] == $past(({1'b0, exec_file_val} + {1'b0, exec_work_val}) > 9'h0ff);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("carry wrong");

   property p_sub_carry;
      @(posedge sys_clk) disable iff (!resetn)
      (exec_valid && exec_op == CSF_OP_SUB)
         |=> core_status_flags[0] == $past(exec_file_val >= exec_work_val)
            && core_status_flags[1] == $past(exec_file_val[3:0] >= exec_work_val[3:0]);
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("borrow wrong");

   property p_ror;
      @(posedge sys_clk) disable iff (!resetn)
      (exec_valid && exec_op == CSF_OP_ROR) |=> core_status_flags[0] == $past(exec_file_val[0]);
   endproperty
   a_ror: assert property (p_ror) else $error("rotate carry wrong");

   property p_addr;
      @(posedge sys_clk) disable iff (!resetn)
      data_mem_addr[7] == bank_select_bit && data_mem_addr[6:0] == exec_dir_addr;
   endproperty
   a_addr: assert property (p_addr) else $error("bank address wrong");
endmodule
